// ---- design/crcmx_checker.sv ----
// Configuration memory CRC checker: sequencer, registers, scan access
`timescale 1ns/1ps
module crcmx_checker
    import crcmx_pkg::*;
#(
    parameter int MEM_WORDS = MEM_WORDS_DEF,       // Memory size in words
    parameter int AW        = $clog2(MEM_WORDS_DEF) // Word address width
) (
    input  wire logic                 clk,             // Configuration oscillator
    input  wire logic                 rst,             // Asynchronous reset, high
    input  wire logic                 ed_enable,       // Error detection option bit
    input  wire logic                 user_mode,       // Device is in user mode
    input  wire logic [DIV_EXP_W-1:0] div_exp,         // Divider exponent n
    input  wire logic                 cfg_load,        // End of configuration pulse
    input  wire logic [SIG_W-1:0]     cfg_crc,         // Precomputed CRC
    output logic      [AW-1:0]        mem_addr,        // Memory word address
    input  wire logic [31:0]          mem_data,        // Word at mem_addr
    input  wire logic                 jtag_tck,        // Test clock pin
    input  wire logic                 jtag_tdi,        // Test data in
    input  wire logic                 jtag_shift_dr,   // TAP in Shift-DR
    input  wire logic                 jtag_capture_dr, // TAP in Capture-DR
    input  wire logic                 jtag_update_dr,  // TAP in Update-DR
    input  wire logic [IR_W-1:0]      jtag_ir,         // Current instruction
    output logic                      jtag_tdo,        // Test data out
    output logic                      soft_err,        // Soft-error flag, high
    output logic                      crc_err_o,       // Open-drain pin level
    output logic                      crc_err_oe,      // Open-drain pin enable
    output logic [SIG_W-1:0]          signature,       // Signature register
    output logic [SIG_W-1:0]          ref_store,       // Reference store
    output logic                      pass_done,       // Pass finished pulse
    output logic                      checking         // Checker running
);
    import crcmx_pkg::*;

    // Notes for whoever wires this block in:
    // - Checking starts once, when enabled in user mode, and never
    //   stops short of reset; there is deliberately no stop input.
    // - mem_data must follow mem_addr in the same cycle; a memory with
    //   a registered read would need one extra wait per word.
    // - Test pins are asynchronous and slow: each test clock phase must
    //   last at least two oscillator cycles or an edge is lost.
    // - A store written by scan counts from the next pass only, so the
    //   pass under way always finishes against its own copy.
    // - The error pin is open drain: pulled low while clean, released
    //   on error, so a board pull-up shows an error as a high level.
    // - Pass length is words times divisor; a large memory at the top
    //   divisor takes long, the price of a slow, low-power check.

    // Whole block state in one record
    typedef struct packed {
        crcmx_state_t         state;   // Idle or running
        logic [DIV_EXP_W-1:0] div;     // Exponent latched at start
        logic [AW-1:0]        addr;    // Word being folded in
        logic [SIG_W-1:0]     crc;     // Running remainder
        logic [SIG_W-1:0]     refv;    // Reference used by this pass
        logic [SIG_W-1:0]     sig;     // Signature register
        logic [SIG_W-1:0]     store;   // Reference store register
        logic [SIG_W-1:0]     shadow;  // Scan chain shift stage
        logic                 err;     // Soft-error flag
        logic                 oe;      // Pin pulled low while clean
        logic                 done;    // End of pass pulse
        logic                 tdo;     // Scan output bit
        logic [JIN_W-1:0]     s1;      // First synchroniser stage
        logic [JIN_W-1:0]     s2;      // Second synchroniser stage
        logic                 tck_d;   // Delayed test clock for edges
    } crcmx_top_st_t;

    // Reset image of the state
    // Pin enable starts high, so the pin reads clean out of reset
    localparam crcmx_top_st_t ST_RESET = '{
        state:  CRCMX_IDLE,
        div:    '0,
        addr:   '0,
        crc:    CRC_INIT,
        refv:   STORE_RESET,
        sig:    SIG_RESET,
        store:  STORE_RESET,
        shadow: STORE_RESET,
        err:    1'b0,
        oe:     1'b1,
        done:   1'b0,
        tdo:    1'b0,
        s1:     '0,
        s2:     '0,
        tck_d:  1'b0
    };

    // Last word address of one pass
    localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_WORDS - 1);

    // Store change decode, honoured only while in user mode
    function automatic logic crcmx_is_scan(input logic [IR_W-1:0] ir_code,
                                           input logic            in_user);
        return (ir_code == IR_STORE_CHANGE) && in_user;
    endfunction

    // Rising edge of a synchronised level against its delayed copy
    function automatic logic crcmx_rise(input logic now_v, input logic was_v);
        return now_v & ~was_v;
    endfunction

    // Last word of a pass under the fold
    function automatic logic crcmx_at_end(input logic [AW-1:0] a);
        return a == LAST_ADDR;
    endfunction

    // One register holds the whole block; fields keep their names
    crcmx_top_st_t st_r;    // Registered state
    crcmx_top_st_t st_nxt;  // Next state

    // Helper nets, driven by the two instances and the small processes below
    logic             tick;      // Checker clock enable
    logic [SIG_W-1:0] crc_step;  // Remainder after current word
    logic [JIN_W-1:0] jin;       // Raw JTAG bundle from the pins
    logic             tck_rise;  // Rising test clock, synchronised
    logic             scan_sel;  // Store change instruction selected
    logic [SIG_W-1:0] sig_new;   // Signature at end of a pass
    logic             pass_end;  // Tick on the last word of a pass

    // Divided checker tick; counts only while the check runs
    // Divider restarts from zero on every start, so its phase is known
    crcmx_clk_div u_div (
        .clk     (clk),
        .rst     (rst),
        .run     (st_r.state == CRCMX_RUN),
        .div_exp (st_r.div),
        .tick    (tick)
    );

    // One memory word folded per tick
    // Combinational fold; the memory read and the fold share a cycle
    crcmx_word_step u_step (
        .crc_in  (st_r.crc),
        .data_in (mem_data),
        .crc_out (crc_step)
    );

    // Scan timing: a test clock edge reaches the second stage one or
    // two oscillator cycles after the pin moves; the third flop only
    // serves to find the edge. Capture copies the store into the shift
    // stage and shows bit zero; each shift takes a host bit in at the
    // top and shows the next bit; update writes the shift stage back
    // into the store. Other pins must be steady around the rise.

    // Pin bundle gathered for the synchroniser
    // Grouping keeps both stages one vector, one flop per pin
    always_comb begin
        jin            = '0;
        jin[J_TCK]     = jtag_tck;
        jin[J_TDI]     = jtag_tdi;
        jin[J_SHIFT]   = jtag_shift_dr;
        jin[J_CAPTURE] = jtag_capture_dr;
        jin[J_UPDATE]  = jtag_update_dr;
        jin[J_IR +: IR_W] = jtag_ir;
    end

    // Decodes taken from the second stage only, never the first
    always_comb begin
        tck_rise = crcmx_rise(st_r.s2[J_TCK], st_r.tck_d);
        scan_sel = crcmx_is_scan(st_r.s2[J_IR +: IR_W], user_mode);
        // Zero exactly when the pass matches its reference
        sig_new  = (crc_step ^ CRC_XOROUT) ^ st_r.refv;
        // Only a divider tick on the last word ends a pass
        pass_end = tick & crcmx_at_end(st_r.addr);
    end

    // Pass timing, divisor D and W words:
    // - the divider ticks every D cycles while the check runs;
    // - each tick folds the word at mem_addr and steps to the next;
    // - the tick on the last word folds it, publishes signature and
    //   flag, pulses pass_done and restarts at word zero;
    // - so a pass is W times D cycles, the first a cycle longer
    //   because the divider's tick is itself registered.

    // Next state for sequencing, result update and scan access
    always_comb begin
        // Every field holds unless a branch below says otherwise
        st_nxt       = st_r;
        // End of pass pulse lasts a single cycle
        st_nxt.done  = 1'b0;
        // Two-stage capture of the slow test pins
        // Third flop keeps the last test clock level for edge finding
        st_nxt.s1    = jin;
        st_nxt.s2    = st_r.s1;
        st_nxt.tck_d = st_r.s2[J_TCK];

        // Reference arrives when configuration finishes
        // A level held high keeps reloading, which is harmless
        if (cfg_load) begin
            st_nxt.store = cfg_crc;
        end

        // Scan chain works beside the checker, which never pauses.
        // Capture, shift and update are exclusive controller states,
        // so the order of the tests only matters for a faulty host.
        if (scan_sel && tck_rise) begin
            if (st_r.s2[J_CAPTURE]) begin
                // Lets the host read the good value before corrupting it
                st_nxt.shadow = st_r.store;
            end else if (st_r.s2[J_SHIFT]) begin
                // Host bit enters at the top, oldest bit leaves below
                st_nxt.shadow = {st_r.s2[J_TDI], st_r.shadow[SIG_W-1:1]};
                // Output shows the bit that the next shift pushes out
                st_nxt.tdo    = st_r.shadow[1];
            end else if (st_r.s2[J_UPDATE] && !cfg_load) begin
                // A configuration load in the same cycle wins
                st_nxt.store = st_r.shadow;
            end
        end
        // First bit out is ready as soon as the value is captured
        if (scan_sel && tck_rise && st_r.s2[J_CAPTURE]) begin
            st_nxt.tdo = st_r.store[0];
        end

        case (st_r.state)
            CRCMX_IDLE: begin
                // Start by itself once enabled and in user mode
                if (ed_enable && user_mode) begin
                    // Exponent frozen so a pass never changes speed
                    st_nxt.state = CRCMX_RUN;
                    st_nxt.div   = div_exp;
                    // Fresh remainder from the first word
                    st_nxt.addr  = '0;
                    st_nxt.crc   = CRC_INIT;
                    st_nxt.refv  = st_r.store;
                end else begin
                    // Wait; nothing is checked before the start
                    st_nxt.state = CRCMX_IDLE;
                end
            end
            CRCMX_RUN: begin
                // No way back to idle short of reset
                st_nxt.state = CRCMX_RUN;
                if (tick) begin
                    if (pass_end) begin
                        // Pass ends: publish result, start over at once
                        st_nxt.sig  = sig_new;
                        st_nxt.err  = |sig_new;
                        // Pin released on error so the pull-up reads high
                        st_nxt.oe   = ~(|sig_new);
                        st_nxt.done = 1'b1;
                        // Next pass restarts at word zero with no gap
                        st_nxt.addr = '0;
                        st_nxt.crc  = CRC_INIT;
                        // Injected store value takes effect next pass
                        st_nxt.refv = st_r.store;
                    end else begin
                        // One word per tick sets the pass length
                        st_nxt.addr = st_r.addr + AW'(1);
                        st_nxt.crc  = crc_step;
                    end
                end
            end
            default: begin
                // Unknown value of the one-bit state field, which has no unused code; recover as if reset
                st_nxt = ST_RESET;
            end
        endcase
    end

    // Single state register for the whole block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Constant image only; no live input in the reset branch
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except the constant pin drive value
    // Word address goes straight from the fold counter
    assign mem_addr   = st_r.addr;
    assign jtag_tdo   = st_r.tdo;
    assign soft_err   = st_r.err;
    // Open drain: drive value fixed low, enable carries the clean state
    assign crc_err_o  = 1'b0;
    assign crc_err_oe = st_r.oe;
    // Register images for read-back by whoever is wired to them
    assign signature  = st_r.sig;
    assign ref_store  = st_r.store;
    assign pass_done  = st_r.done;
    // Running flag taken from the one-bit state
    assign checking   = (st_r.state == CRCMX_RUN);
endmodule

// ---- design/crcmx_clk_div.sv ----
// Power-of-two tick divider producing the checker clock enable
`timescale 1ns/1ps
module crcmx_clk_div
    import crcmx_pkg::*;
(
    input  wire logic                 clk,      // Configuration oscillator
    input  wire logic                 rst,      // Asynchronous reset, high
    input  wire logic                 run,      // Divider counts while high
    input  wire logic [DIV_EXP_W-1:0] div_exp,  // Exponent n, clamped to 8
    output logic                      tick      // One-cycle checker tick
);
    import crcmx_pkg::*;

    // Divider state
    typedef struct packed {
        logic [DIV_CNT_W-1:0] cnt;   // Cycles since last tick
        logic                 tick;  // Registered tick
    } crcmx_div_st_t;

    crcmx_div_st_t st_r;   // Registered state
    crcmx_div_st_t st_nxt; // Next state

    logic [DIV_EXP_W-1:0] n_eff;  // Clamped exponent
    logic [DIV_CNT_W:0]   span;   // Divisor two to the n
    logic [DIV_CNT_W-1:0] last;   // Terminal count, divisor minus one

    // Terminal count from the exponent; out of range values act as 8
    always_comb begin
        n_eff = (div_exp > DIV_EXP_LIM) ? DIV_EXP_LIM : div_exp;
        span  = (DIV_CNT_W + 1)'(1) << n_eff;
        last  = DIV_CNT_W'(span - (DIV_CNT_W + 1)'(1));
    end

    // Count up and emit one tick every divisor cycles
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == last) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + DIV_CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// ---- design/crcmx_pkg.sv ----
// Shared constants and types for the configuration memory CRC checker
package crcmx_pkg;
    // Signature and reference widths
    localparam int          SIG_W           = 32;
    // Instruction register width and store change instruction code
    localparam int          IR_W            = 10;
    localparam logic [9:0]  IR_STORE_CHANGE = 10'h015;
    // CRC-32 (IEEE 802) reflected generator, preset and final inversion
    localparam logic [31:0] CRC_POLY_REFL   = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_XOROUT      = 32'hFFFFFFFF;
    // Reset values of the two checker registers
    localparam logic [31:0] SIG_RESET       = 32'h00000000;
    localparam logic [31:0] STORE_RESET     = 32'h00000000;
    // Divider exponent field: divisor is two to the power n, n in 0..8
    localparam int          DIV_EXP_W       = 4;
    localparam logic [3:0]  DIV_EXP_LIM     = 4'h8;
    localparam int          DIV_CNT_W       = 8;
    // Checker clock limits, fastest in kHz and slowest in Hz
    localparam int          CHK_FMAX_KHZ    = 80000;
    localparam int          CHK_FMIN_HZ     = 312500;
    // Oscillator period used by this build, in ps
    localparam int          CLK_PERIOD_PS   = 25000;
    // Default configuration memory size in 32-bit words
    localparam int          MEM_WORDS_DEF   = 1024;
    // Bit positions of the synchronised JTAG bundle
    localparam int          J_TCK           = 0;
    localparam int          J_TDI           = 1;
    localparam int          J_SHIFT         = 2;
    localparam int          J_CAPTURE       = 3;
    localparam int          J_UPDATE        = 4;
    localparam int          J_IR            = 5;
    localparam int          JIN_W           = 5 + IR_W;

    // Checker sequencing states
    typedef enum logic [0:0] {
        CRCMX_IDLE = 1'b0,
        CRCMX_RUN  = 1'b1
    } crcmx_state_t;
endpackage

// ---- design/crcmx_word_step.sv ----
// One 32-bit word of CRC-32 accumulation, purely combinational
`timescale 1ns/1ps
module crcmx_word_step
    import crcmx_pkg::*;
(
    input  wire logic [31:0] crc_in,   // Running remainder
    input  wire logic [31:0] data_in,  // Memory word, bit 0 first
    output logic      [31:0] crc_out   // Remainder after the word
);
    import crcmx_pkg::*;

    // Bitwise reflected CRC, least significant data bit enters first
    function automatic logic [31:0] crcmx_fold(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 32; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ CRC_POLY_REFL;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    // Single word per checker tick keeps the pass length one tick per word
    always_comb begin
        crc_out = crcmx_fold(crc_in, data_in);
    end
endmodule

// ---- test/crcmx_checker_sva.sv ----
// Port-level assertions for the configuration memory CRC checker
`timescale 1ns/1ps
module crcmx_checker_sva #(
    parameter int MEM_WORDS = crcmx_pkg::MEM_WORDS_DEF, // Words per pass
    parameter int AW        = 10                        // Address width
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        ed_enable,
    input wire logic                        user_mode,
    input wire logic                        cfg_load,
    input wire logic [crcmx_pkg::SIG_W-1:0] cfg_crc,
    input wire logic [AW-1:0]               mem_addr,
    input wire logic                        soft_err,
    input wire logic                        crc_err_o,
    input wire logic                        crc_err_oe,
    input wire logic [crcmx_pkg::SIG_W-1:0] signature,
    input wire logic [crcmx_pkg::SIG_W-1:0] ref_store,
    input wire logic                        pass_done,
    input wire logic                        checking
);
    import crcmx_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Pass end marker
    sequence s_end;
        pass_done;
    endsequence
    // Quiet gap; a four-word pass lasts at least four cycles
    sequence s_gap;
        !pass_done [*3];
    endsequence
    a_flag_from_sig: assert property (soft_err == (signature != '0))
        else $error("flag disagrees with signature");
    a_pin_drive: assert property (crc_err_o == 1'b0 && crc_err_oe == !soft_err)
        else $error("pin drive disagrees with flag");
    a_sig_at_end: assert property (!pass_done |-> $stable(signature))
        else $error("signature moved mid pass");
    a_flag_at_end: assert property ($changed(soft_err) |-> s_end)
        else $error("flag moved mid pass");
    a_keep_running: assert property (checking |=> checking)
        else $error("checking stopped");
    a_auto_start: assert property (!checking && ed_enable && user_mode |=> checking && mem_addr == '0)
        else $error("no automatic start");
    a_ref_load: assert property (cfg_load |=> ref_store == $past(cfg_crc))
        else $error("reference not loaded");
    a_pass_gap: assert property (s_end |=> s_gap)
        else $error("passes too close");
    a_addr_wrap: assert property (s_end |-> mem_addr == '0)
        else $error("address not wrapped");
    a_idle_clean: assert property (!checking |-> !soft_err && !pass_done)
        else $error("activity before start");
endmodule
bind crcmx_checker crcmx_checker_sva #(.MEM_WORDS(MEM_WORDS), .AW(AW)) u_sva (
    .clk(clk), .rst(rst), .ed_enable(ed_enable), .user_mode(user_mode),
    .cfg_load(cfg_load), .cfg_crc(cfg_crc), .mem_addr(mem_addr), .soft_err(soft_err),
    .crc_err_o(crc_err_o), .crc_err_oe(crc_err_oe), .signature(signature),
    .ref_store(ref_store), .pass_done(pass_done), .checking(checking));

// ---- test/crcmx_checker_tb.sv ----
// Self-checking bench for the configuration memory CRC checker
`timescale 1ns/1ps
module crcmx_checker_tb;
    import crcmx_pkg::*;
    localparam int WORDS = 4; // Short memory keeps passes brief
    logic        clk, rst, ed_enable, user_mode, cfg_load, tck, tdi;
    logic        shift_dr, capture_dr, update_dr, tdo, soft_err, err_o, err_oe;
    logic        pass_done, checking;
    logic [3:0]  div_exp;
    logic [1:0]  mem_addr;
    logic [9:0]  ir;
    logic [31:0] cfg_crc, flip, mem_data, signature, ref_store, good;
    int          fail_count, n_checks, cyc;

    crcmx_checker #(.MEM_WORDS(WORDS), .AW(2)) DUT (.clk(clk), .rst(rst),
        .ed_enable(ed_enable), .user_mode(user_mode), .div_exp(div_exp),
        .cfg_load(cfg_load), .cfg_crc(cfg_crc), .mem_addr(mem_addr), .mem_data(mem_data),
        .jtag_tck(tck), .jtag_tdi(tdi), .jtag_shift_dr(shift_dr),
        .jtag_capture_dr(capture_dr), .jtag_update_dr(update_dr), .jtag_ir(ir),
        .jtag_tdo(tdo), .soft_err(soft_err), .crc_err_o(err_o), .crc_err_oe(err_oe),
        .signature(signature), .ref_store(ref_store), .pass_done(pass_done),
        .checking(checking));
    crcmx_mem_model #(.AW(2)) u_mem (.mem_addr(mem_addr), .flip(flip), .mem_data(mem_data));

    // 40 MHz oscillator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, well above the longest sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // Drives land just after the edge so no race with the design
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Bench's own CRC-32 over the model pattern, bit 0 of word 0 first
    function automatic logic [31:0] crc_of(input logic [31:0] f);
        logic [31:0] c, w;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < WORDS; i++) begin
            w = (32'hC35A0000 | 32'(i)) ^ ((i == 1) ? f : 32'h00000000);
            for (int b = 0; b < 32; b++) begin
                c = (c[0] ^ w[b]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
            end
        end
        return ~c;
    endfunction
    task automatic do_reset();
        rst = 1'b1;
        {ed_enable, user_mode, cfg_load, tck, tdi, shift_dr, capture_dr, update_dr} = 8'h00;
        {div_exp, cfg_crc, flip, ir} = {4'h0, 32'h00000000, 32'h00000000, 10'h000};
        step(3);
        rst = 1'b0;
    endtask
    task automatic start(input int n);
        cfg_crc = good;
        cfg_load = 1'b1;
        step(1);
        cfg_load = 1'b0;
        div_exp = 4'(n);
        {ed_enable, user_mode} = 2'b11;
        step(1);
    endtask
    task automatic wait_pass(output int k);
        k = 0;
        do begin
            step(1);
            k++;
        end while (pass_done !== 1'b1 && k < 3000);
        check(k < 3000, "no pass end");
    endtask
    // Test clock low then high, four oscillator cycles each; pins set
    // before the call have settled at the rise and change at the fall
    task automatic tck_pulse();
        step(4);
        tck = 1'b1;
        step(4);
        tck = 1'b0;
    endtask
    task automatic t_reset();
        user_mode = 1'b1;
        step(10);
        check(signature === 32'h00000000 && ref_store === 32'h00000000, "reset regs");
        check(soft_err === 1'b0 && err_oe === 1'b1 && err_o === 1'b0, "reset flag");
        check(checking === 1'b0, "started while disabled");
        $display("t_reset done");
    endtask
    task automatic t_clean();
        int k;
        start(0);
        wait_pass(k);
        check(ref_store === good && checking === 1'b1, "start");
        check(signature === 32'h00000000 && soft_err === 1'b0, "clean pass");
        $display("t_clean done");
    endtask
    task automatic t_error();
        int k;
        flip = 32'h00000100;
        wait_pass(k);
        check(signature === (crc_of(flip) ^ good), "upset signature");
        check(soft_err === 1'b1 && err_oe === 1'b0, "flag not raised");
        wait_pass(k);
        check(soft_err === 1'b1, "flag dropped early");
        flip = 32'h00000000;
        wait_pass(k);
        check(soft_err === 1'b0 && signature === 32'h00000000, "flag stuck");
        $display("t_error done");
    endtask
    task automatic t_scan();
        logic [31:0] rd, nv;
        int          n;
        nv = good ^ 32'h80000001;
        ir = 10'h016;
        update_dr = 1'b1;
        tck_pulse();
        update_dr = 1'b0;
        check(ref_store === good, "update under another code");
        ir = 10'h015;
        capture_dr = 1'b1;
        tck_pulse();
        capture_dr = 1'b0;
        shift_dr = 1'b1;
        for (int k = 0; k < 32; k++) begin
            rd[k] = tdo;
            tdi = nv[k];
            tck_pulse();
        end
        shift_dr = 1'b0;
        update_dr = 1'b1;
        tck_pulse();
        update_dr = 1'b0;
        check(rd === good && ref_store === nv, "scan access");
        wait_pass(n);
        check(checking === 1'b1 && n <= WORDS, "halted by scan");
        wait_pass(n);
        check(signature === (good ^ nv), "new reference");
        $display("t_scan done");
    endtask
    task automatic t_div();
        int a, b;
        for (int n = 0; n < 10; n++) begin
            do_reset();
            start(n);
            wait_pass(a);
            wait_pass(b);
            check(b == WORDS * (1 << ((n > 8) ? 8 : n)), "pass length");
        end
        $display("t_div done");
    endtask
    initial begin
        good = crc_of(32'h00000000);
        do_reset();
        t_reset();
        t_clean();
        t_error();
        t_scan();
        t_div();
        final_report();
    end
endmodule

// ---- test/crcmx_mem_model.sv ----
// Configuration memory model answering the checker's word reads
`timescale 1ns/1ps
module crcmx_mem_model #(
    parameter int AW = 2 // Word address width
) (
    input  wire logic [AW-1:0] mem_addr, // Word requested
    input  wire logic [31:0]   flip,     // Upset mask on word one
    output logic      [31:0]   mem_data  // Contents, asynchronous read
);
    // Fixed pattern; an upset is only seen while the bench holds it
    always_comb begin
        mem_data = 32'hC35A0000 | 32'(mem_addr);
        if (mem_addr == AW'(1)) begin
            mem_data = mem_data ^ flip;
        end
    end
endmodule
